// >>> logic/uibd_pkg.sv
// constants shared by the input endpoint descriptor block and its buffer.
// assumes a 32-bit apb master and a buffer manager on the same clock.
package uibd_pkg;

    localparam int NUM_IN_EP = 3;
    localparam int APB_ADDR_W = 12;
    localparam int MEM_ADDR_W = 11;
    localparam int ADDR_PAD_BITS = 3;
    localparam int CNT_W = 7;
    localparam int FLAG_BIT = 7;
    localparam int RSP_W = 1 + 1 + 2 + MEM_ADDR_W + CNT_W;

    ////////////////////////////////////////////////////////////////////////
    // register map: one 16-byte group per endpoint, endpoint 1 at 0x000
    localparam logic [11:0] EP_STRIDE = 12'h010;
    localparam logic [11:0] OFF_X_COUNT = 12'h000;
    localparam logic [11:0] OFF_Y_BASE = 12'h004;
    localparam logic [11:0] OFF_Y_COUNT = 12'h008;
    localparam logic [11:0] OFF_EP_CONFIG = 12'h00C;
    localparam int EP_FIELD_LSB = 4;
    localparam int REG_FIELD_LSB = 2;
    localparam int MAP_TOP_LSB = 6;

    localparam logic [1:0] SEL_X_COUNT = 2'h0;
    localparam logic [1:0] SEL_Y_BASE = 2'h1;
    localparam logic [1:0] SEL_Y_COUNT = 2'h2;
    localparam logic [1:0] SEL_EP_CONFIG = 2'h3;

    localparam int CFG_DOUBLE_BUFFER_ENABLE_BIT = 0;
    localparam int CFG_TOGGLE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // values after reset: buffers empty, so every in request is refused
    localparam logic [7:0] RST_COUNT_STATUS = 8'h80;
    localparam logic [7:0] RST_Y_BASE = 8'h00;
    localparam logic RST_DOUBLE_BUFFER_ENABLE = 1'b0;
    localparam logic RST_TOGGLE = 1'b0;

    typedef struct packed {
        logic hit;
        logic [1:0] ep;
        logic [1:0] sel;
    } uibd_dec_t;

endpackage

// >>> logic/uibd_pair_buffer.sv
// small fifo holding descriptor answers on their way to the buffer manager.
// assumes the reader may stall; the writer watches inReady.
`timescale 1ns/1ns
module uibd_pair_buffer
    import uibd_pkg::*;
#(
    parameter int WIDTH = RSP_W,
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("uibd_pair_buffer: DEPTH must be a power of two >= 2");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0] cnt;
    } uibd_buf_state_t;

    uibd_buf_state_t st_ff;
    uibd_buf_state_t nxt_st;
    logic push;
    logic pop;

    assign inReady = (st_ff.cnt != DEPTH_C);
    assign outValid = (st_ff.cnt != '0);
    assign outData = st_ff.mem[st_ff.rd];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = inData;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        // a full buffer refuses the push, so no word is overwritten
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// >>> logic/uibd_in_ep_desc.sv
// input endpoint buffer descriptors with apb access and a lookup port
// for the usb buffer manager.
// assumes the buffer manager acknowledges each sent packet with ackValid
// and that every apb and manager signal is synchronous to mclk.
//
// Functional notes
// - three endpoints each own x count, y base and y count registers
// - packet length is a binary byte count 0..64 in bits 6..0
// - flag bit 7 clear means valid packet, sent on next in request
// - flag bit 7 set means empty buffer, in request answered with nak
// - y start address is the 8-bit field over three zero bits
// - base address starts each transfer and is never changed by it
// - with double buffering the toggle picks x or y, else x only
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
module uibd_in_ep_desc
    import uibd_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W,
    parameter int NUM_EP = NUM_IN_EP,
    parameter int BUF_DEPTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inReqValid,
    output logic inReqReady,
    input wire logic [1:0] inReqEp,
    input wire logic [NUM_EP-1:0][7:0] xBaseField,
    output logic rspValid,
    input wire logic rspReady,
    output logic rspNak,
    output logic rspBufY,
    output logic [1:0] rspEp,
    output logic [MEM_ADDR_W-1:0] rspAddr,
    output logic [CNT_W-1:0] rspCount,
    input wire logic ackValid,
    input wire logic [1:0] ackEp,
    input wire logic ackBufY,
    output logic [NUM_EP-1:0] dataToggle
);

    localparam logic [1:0] EP_MAX = 2'(NUM_EP);

    initial begin
        if (NUM_EP < 1 || NUM_EP > 3 || ADDR_W < MAP_TOP_LSB + 1) begin
            $error("uibd_in_ep_desc: NUM_EP 1..3, ADDR_W >= 7 required");
        end
    end

    initial begin
        if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin
            $error("uibd_in_ep_desc: BUF_DEPTH must be a power of two >= 2");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic uibd_dec_t decode(input logic [ADDR_W-1:0] a);
        uibd_dec_t d;
        d.ep = a[EP_FIELD_LSB +: 2];
        d.sel = a[REG_FIELD_LSB +: 2];
        d.hit = (a[ADDR_W-1:MAP_TOP_LSB] == '0) && (a[1:0] == 2'h0)
            && (d.ep < EP_MAX);
        return d;
    endfunction

    // field is address bits 10..3; the low bits are always zero
    function automatic logic [MEM_ADDR_W-1:0] startAddr(input logic [7:0] f);
        return {f, {ADDR_PAD_BITS{1'b0}}};
    endfunction

    function automatic logic epInRange(input logic [1:0] ep);
        return (ep != 2'h0) && (ep <= EP_MAX);
    endfunction

    // endpoint numbers start at one; callers check the range before using the index
    function automatic logic [1:0] epIndex(input logic [1:0] ep);
        return ep - 2'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    // one flop set for all registers keeps reset and update together

    typedef struct packed {
        logic [NUM_EP-1:0][7:0] xCnt;
        logic [NUM_EP-1:0][7:0] yBase;
        logic [NUM_EP-1:0][7:0] yCnt;
        logic [NUM_EP-1:0] double_buffer_enable;
        logic [NUM_EP-1:0] toggle;
        logic [31:0] rdata;
    } uibd_state_t;

    uibd_state_t st_ff;
    uibd_state_t nxt_st;

    uibd_dec_t dec;
    logic apbWrite;
    logic apbSetupRead;

    logic reqOk;
    logic [1:0] reqIdx;
    logic reqUseY;
    logic [7:0] reqDesc;
    logic [RSP_W-1:0] reqWord;
    logic [RSP_W-1:0] rspWord;
    logic bufInReady;
    logic [1:0] ackIdx;

    assign dec = decode(paddr);
    assign apbWrite = psel && penable && pwrite && dec.hit;
    assign apbSetupRead = psel && !penable && !pwrite;
    // zero wait states: read data was captured in the setup cycle
    assign pready = 1'b1;
    // misaligned or unmapped words are refused and their writes dropped
    assign pslverr = psel && penable && !dec.hit;
    assign prdata = st_ff.rdata;
    assign dataToggle = st_ff.toggle;
    assign ackIdx = epIndex(ackEp);

    ////////////////////////////////////////////////////////////////////////
    // lookup for the buffer manager

    always_comb begin
        reqOk = epInRange(inReqEp);
        // an unknown endpoint still gets an answer, but always a nak
        reqIdx = reqOk ? epIndex(inReqEp) : 2'h0;
        reqUseY = reqOk && st_ff.double_buffer_enable[reqIdx]
            && st_ff.toggle[reqIdx];
        reqDesc = reqUseY ? st_ff.yCnt[reqIdx] : st_ff.xCnt[reqIdx];
        // x base lives outside this block, so it comes straight from the port
        reqWord = {
            !reqOk || reqDesc[FLAG_BIT],
            reqUseY,
            inReqEp,
            reqUseY ? startAddr(st_ff.yBase[reqIdx])
                    : startAddr(xBaseField[reqIdx]),
            reqDesc[CNT_W-1:0]
        };
    end

    // stalls at the manager back up into inReqReady, losing no answer
    assign inReqReady = bufInReady;

    uibd_pair_buffer #(
        .WIDTH(RSP_W),
        .DEPTH(BUF_DEPTH)
    ) u_rsp_buf (
        .mclk(mclk),
        .reset_n(reset_n),
        .inValid(inReqValid),
        .inReady(bufInReady),
        .inData(reqWord),
        .outValid(rspValid),
        .outReady(rspReady),
        .outData(rspWord)
    );

    assign {rspNak, rspBufY, rspEp, rspAddr, rspCount} = rspWord;

    ////////////////////////////////////////////////////////////////////////
    // register file

    always_comb begin
        nxt_st = st_ff;
        if (apbSetupRead) begin
            // unmapped words read as zero, so software sees no aliases
            nxt_st.rdata = 32'h0000_0000;
            if (dec.hit) begin
                unique case (dec.sel)
                    SEL_X_COUNT: nxt_st.rdata[7:0] = st_ff.xCnt[dec.ep];
                    SEL_Y_BASE: nxt_st.rdata[7:0] = st_ff.yBase[dec.ep];
                    SEL_Y_COUNT: nxt_st.rdata[7:0] = st_ff.yCnt[dec.ep];
                    SEL_EP_CONFIG: begin
                        nxt_st.rdata[CFG_DOUBLE_BUFFER_ENABLE_BIT] = st_ff.double_buffer_enable[dec.ep];
                        nxt_st.rdata[CFG_TOGGLE_BIT] = st_ff.toggle[dec.ep];
                    end
                endcase
            end
        end
        // counts above 64 are stored as written; firmware must avoid them
        if (apbWrite) begin
            unique case (dec.sel)
                SEL_X_COUNT: nxt_st.xCnt[dec.ep] = pwdata[7:0];
                SEL_Y_BASE: nxt_st.yBase[dec.ep] = pwdata[7:0];
                SEL_Y_COUNT: nxt_st.yCnt[dec.ep] = pwdata[7:0];
                SEL_EP_CONFIG: begin
                    nxt_st.double_buffer_enable[dec.ep] = pwdata[CFG_DOUBLE_BUFFER_ENABLE_BIT];
                    nxt_st.toggle[dec.ep] = pwdata[CFG_TOGGLE_BIT];
                end
            endcase
        end
        // applied after the write so the hardware set wins a collision
        if (ackValid && epInRange(ackEp)) begin
            if (ackBufY) begin
                nxt_st.yCnt[ackIdx][FLAG_BIT] = 1'b1;
            end else begin
                nxt_st.xCnt[ackIdx][FLAG_BIT] = 1'b1;
            end
            // the next packet of this endpoint goes out with the other pid
            nxt_st.toggle[ackIdx] = ~st_ff.toggle[ackIdx];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff.xCnt <= {NUM_EP{RST_COUNT_STATUS}};
            st_ff.yBase <= {NUM_EP{RST_Y_BASE}};
            st_ff.yCnt <= {NUM_EP{RST_COUNT_STATUS}};
            st_ff.double_buffer_enable <= {NUM_EP{RST_DOUBLE_BUFFER_ENABLE}};
            st_ff.toggle <= {NUM_EP{RST_TOGGLE}};
            st_ff.rdata <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// >>> sim/uibd_in_ep_desc_chk.sv
// port checker for the input endpoint descriptor block.
// assumes one clock domain; bound from the bench top.
`timescale 1ns/1ns
module uibd_in_ep_desc_chk
    import uibd_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W,
    parameter int NUM_EP = NUM_IN_EP
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pslverr,
    input wire logic inReqValid,
    input wire logic inReqReady,
    input wire logic [1:0] inReqEp,
    input wire logic [NUM_EP-1:0][7:0] xBaseField,
    input wire logic rspValid,
    input wire logic rspReady,
    input wire logic rspNak,
    input wire logic rspBufY,
    input wire logic [MEM_ADDR_W-1:0] rspAddr,
    input wire logic [CNT_W-1:0] rspCount,
    input wire logic ackValid,
    input wire logic [1:0] ackEp,
    input wire logic [NUM_EP-1:0] dataToggle
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    bad_addr_a: assert property (
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    pad_zero_a: assert property (
        rspValid |-> rspAddr[2:0] == 3'h0)
        else $error("start address low bits not zero");
    x_base_a: assert property (
        inReqValid && inReqReady && !rspValid && inReqEp == 2'h1
        && !dataToggle[0] |=> !rspBufY
        && rspAddr == {$past(xBaseField[0]), 3'h0})
        else $error("x buffer address wrong");
    ans_next_a: assert property (
        inReqValid && inReqReady && !rspValid |=> rspValid)
        else $error("lookup not answered next cycle");
    rsp_hold_a: assert property (
        rspValid && !rspReady |=> rspValid
        && $stable({rspNak, rspBufY, rspAddr, rspCount}))
        else $error("stalled answer changed");
    ack_flip_a: assert property (
        ackValid && ackEp == 2'h1 |=> dataToggle[0] != $past(dataToggle[0]))
        else $error("toggle not flipped by ack");
    tog_hold_a: assert property (
        !ackValid && !(psel && penable && pwrite) |=> $stable(dataToggle))
        else $error("toggle moved by itself");
    count_max_a: assert property (
        rspValid |-> rspCount <= 7'h40)
        else $error("count above 64 bytes");
    stall_c: cover property (rspValid && !rspReady ##1 !inReqReady);
    ybuf_c: cover property (rspValid && rspReady && rspBufY);
    nak_c: cover property (rspValid && rspReady && rspNak);
endmodule

// >>> sim/uibd_bm_model.sv
// buffer manager stand-in: lookups, answer capture, acks.
// assumes tasks are entered just after a rising edge.
`timescale 1ns/1ns
module uibd_bm_model
    import uibd_pkg::*;
(
    input wire logic mclk,
    input wire logic stall,
    input wire logic inReqReady,
    input wire logic rspValid,
    input wire logic [1:0] rspEp,
    input wire logic rspNak,
    input wire logic rspBufY,
    input wire logic [MEM_ADDR_W-1:0] rspAddr,
    input wire logic [CNT_W-1:0] rspCount,
    output logic inReqValid,
    output logic [1:0] inReqEp,
    output logic rspReady,
    output logic ackValid,
    output logic [1:0] ackEp,
    output logic ackBufY
);
    logic [RSP_W-1:0] got[$];
    assign rspReady = !stall;
    initial begin
        inReqValid = 1'b0;
        inReqEp = 2'h0;
        ackValid = 1'b0;
        ackEp = 2'h0;
        ackBufY = 1'b0;
    end
    // answers count only on a real handshake
    always @(posedge mclk) begin
        if (rspValid === 1'b1 && rspReady === 1'b1) begin
            got.push_back({rspEp, rspNak, rspBufY, rspAddr,
                rspCount});
        end
    end
    task automatic req(input logic [1:0] ep, output bit ok);
        int n;
        inReqValid <= 1'b1;
        inReqEp <= ep;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (inReqReady !== 1'b1 && n < 50);
        ok = (inReqReady === 1'b1);
        inReqValid <= 1'b0;
        // released lines show the inverse, so stale values cannot pass
        inReqEp <= ~ep;
        @(posedge mclk);
    endtask
    task automatic ack(input logic [1:0] ep, input logic y);
        ackValid <= 1'b1;
        ackEp <= ep;
        ackBufY <= y;
        @(posedge mclk);
        ackValid <= 1'b0;
        ackEp <= ~ep;
        ackBufY <= ~y;
        @(posedge mclk);
    endtask
endmodule

// >>> sim/uibd_in_ep_desc_tb_top.sv
// bench top: apb master, buffer manager model and scenarios.
// assumes zero-wait apb and answers in request order.
`timescale 1ns/1ns
module uibd_in_ep_desc_tb_top
    import uibd_pkg::*;
;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, stall;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic inReqValid, inReqReady, rspValid, rspReady, rspNak, rspBufY;
    logic ackValid, ackBufY;
    logic [1:0] inReqEp, rspEp, ackEp;
    logic [2:0][7:0] xBaseField;
    logic [2:0] dataToggle;
    logic [10:0] rspAddr;
    logic [6:0] rspCount;
    int error_cnt = 0;
    int n_checks = 0;
    uibd_in_ep_desc i_dut (.mclk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .inReqValid,
        .inReqReady, .inReqEp, .xBaseField, .rspValid, .rspReady, .rspNak,
        .rspBufY, .rspEp, .rspAddr, .rspCount, .ackValid, .ackEp, .ackBufY,
        .dataToggle);
    uibd_bm_model i_bm (.mclk, .stall, .inReqReady, .rspValid, .rspEp,
        .rspNak, .rspBufY, .rspAddr, .rspCount, .inReqValid, .inReqEp,
        .rspReady, .ackValid, .ackEp, .ackBufY);
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        if (pready !== 1'b1) begin
            error_cnt++;
        end
        @(posedge mclk);
    endtask
    function automatic logic [11:0] ra(int ep, logic [11:0] off);
        return 12'(EP_STRIDE * (ep - 1)) + off;
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x,
            input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x);
        chk(32'(e), 32'(xe));
    endtask
    function automatic logic [RSP_W-1:0] rs(int ep, logic nak, logic y,
            logic [7:0] base, logic [6:0] cnt);
        return {2'(ep), nak, y, base, 3'h0, cnt};
    endfunction
    task automatic lk(input int ep, input logic [RSP_W-1:0] x);
        bit ok;
        int n;
        i_bm.req(2'(ep), ok);
        n = 0;
        while (i_bm.got.size() == 0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (!ok || i_bm.got.size() == 0) begin
            error_cnt++;
        end else begin
            chk(32'(i_bm.got.pop_front()), 32'(x));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int ep = 1; ep <= 3; ep++) begin
            rdc(ra(ep, OFF_X_COUNT), 32'h0000_0080, 1'b0);
            rdc(ra(ep, OFF_Y_BASE), 32'h0000_0000, 1'b0);
            rdc(ra(ep, OFF_Y_COUNT), 32'h0000_0080, 1'b0);
        end
        rdc(12'h030, 32'h0000_0000, 1'b1);
        rdc(12'h001, 32'h0000_0000, 1'b1);
        lk(1, rs(1, 1'b1, 1'b0, 8'hA1, 7'h00));
        $display("reset test done");
    endtask
    task automatic t_xbuf;
        logic [6:0] c;
        for (int ep = 1; ep <= 3; ep++) begin
            // firmware never loads more than 64 bytes
            c = (ep == 1) ? 7'h40 : (ep == 2) ? 7'h00 : 7'h3F;
            wr(ra(ep, OFF_X_COUNT), {25'h0, c});
            wr(ra(ep, OFF_Y_BASE), 32'(8'h11 * ep));
            wr(ra(ep, OFF_Y_COUNT), 32'h0000_0005);
            rdc(ra(ep, OFF_X_COUNT), {25'h0, c}, 1'b0);
            lk(ep, rs(ep, 1'b0, 1'b0, 8'(8'hA0 + ep), c));
        end
        lk(0, rs(0, 1'b1, 1'b0, 8'hA1, 7'h40));
        $display("x buffer test done");
    endtask
    task automatic t_ybuf;
        wr(ra(1, OFF_EP_CONFIG), 32'h0000_0003);
        lk(1, rs(1, 1'b0, 1'b1, 8'h11, 7'h05));
        i_bm.ack(2'h1, 1'b1);
        rdc(ra(1, OFF_Y_COUNT), 32'h0000_0085, 1'b0);
        rdc(ra(1, OFF_EP_CONFIG), 32'h0000_0001, 1'b0);
        rdc(ra(1, OFF_Y_BASE), 32'h0000_0011, 1'b0);
        lk(1, rs(1, 1'b0, 1'b0, 8'hA1, 7'h40));
        i_bm.ack(2'h1, 1'b0);
        rdc(ra(1, OFF_X_COUNT), 32'h0000_00C0, 1'b0);
        lk(1, rs(1, 1'b1, 1'b1, 8'h11, 7'h05));
        $display("y buffer test done");
    endtask
    task automatic t_stall;
        bit ok;
        stall <= 1'b1;
        fork
            repeat (3) i_bm.req(2'h3, ok);
            begin
                repeat (8) @(posedge mclk);
                chk(32'(inReqReady), 32'h0000_0000);
                stall <= 1'b0;
            end
        join
        repeat (4) @(posedge mclk);
        chk(32'(i_bm.got.size()), 32'h0000_0003);
        while (i_bm.got.size() > 0) begin
            chk(32'(i_bm.got.pop_front()),
                32'(rs(3, 1'b0, 1'b0, 8'hA3, 7'h3F)));
        end
        $display("stall test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        stall = 1'b0;
        xBaseField = {8'hA3, 8'hA2, 8'hA1};
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_xbuf;
        t_ybuf;
        t_stall;
        end_sim;
    end
endmodule
bind uibd_in_ep_desc uibd_in_ep_desc_chk #(.ADDR_W(ADDR_W), .NUM_EP(NUM_EP))
    i_chk (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pslverr,
    .inReqValid, .inReqReady, .inReqEp, .xBaseField, .rspValid, .rspReady,
    .rspNak, .rspBufY, .rspAddr, .rspCount, .ackValid, .ackEp, .dataToggle);
